// ---- inc/sfwf_map.vh ----
`ifndef SFWF_MAP_VH
`define SFWF_MAP_VH

// Word registers
`define SFWF_A_TAG 8'h78
`define SFWF_A_BYTE0 8'h79
`define SFWF_A_BYTE1 8'h7A
`define SFWF_A_BYTE2 8'h7B
`define SFWF_A_BYTE3 8'h7C
`define SFWF_A_BYTE4 8'h7D
`define SFWF_A_BYTE5 8'h7E

// Configuration and status registers
`define SFWF_A_BRATE 8'h10
`define SFWF_A_ORATE 8'h11
`define SFWF_A_MODE 8'h12
`define SFWF_A_GYCFG 8'h13
`define SFWF_A_XLCFG 8'h14
`define SFWF_A_BATCH 8'h15
`define SFWF_A_AUXV 8'h16
`define SFWF_A_LEVEL 8'h17

// Reset value of every configuration register
`define SFWF_CFG_RST 8'h00

// BATCH register bits
`define SFWF_B_CH2_HOST 0
`define SFWF_B_CH2_FSM 1
`define SFWF_B_NOTCH 2
`define SFWF_B_CFGCHG 3
`define SFWF_B_COMPR 4
`define SFWF_B_TS_EN 5
`define SFWF_B_PEDO 6
`define SFWF_B_STEP 7

// AUXV register bits
`define SFWF_B_ROT 4
`define SFWF_B_GRAV 5
`define SFWF_B_BIAS 6

// Source codes in tag bits 7:3
`define SFWF_T_EMPTY 5'h00
`define SFWF_T_GYRO 5'h01
`define SFWF_T_ACCEL 5'h02
`define SFWF_T_TEMP 5'h03
`define SFWF_T_TS 5'h04
`define SFWF_T_CFG 5'h05
`define SFWF_T_STEP 5'h12
`define SFWF_T_ROT 5'h13
`define SFWF_T_BIAS 5'h16
`define SFWF_T_GRAV 5'h17
`define SFWF_T_CH2 5'h1D
`define SFWF_T_FE 5'h1F

// Timestamp decimation periods in time slots
`define SFWF_DEC1 6'h01
`define SFWF_DEC2 6'h08
`define SFWF_DEC3 6'h20

// Gyroscope startup time
`define SFWF_GYRO_START_MS 70
`define SFWF_CLK_KHZ 25000

`endif

// ---- verilog/sfwf_formatter.v ----
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "sfwf_map.vh"

module sfwf_formatter #(
  parameter DEPTH = 8,
  parameter AW = 3,
  parameter GYRO_START_CYCLES = `SFWF_GYRO_START_MS * `SFWF_CLK_KHZ
) (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Rate ticks from the sensor path
  input wire accel_bdr_tick,
  input wire gyro_bdr_tick,
  input wire accel_odr_tick,
  input wire fe_tick_240,
  input wire temp_tick,
  input wire fusion_tick,
  input wire step_evt,
  input wire ch2_fsm_request,
  // Sample data
  input wire [15:0] accel_x,
  input wire [15:0] accel_y,
  input wire [15:0] accel_z,
  input wire [15:0] gyro_x,
  input wire [15:0] gyro_y,
  input wire [15:0] gyro_z,
  input wire [15:0] ch2_x,
  input wire [15:0] ch2_y,
  input wire [15:0] ch2_z,
  input wire [15:0] fe_sample,
  input wire [15:0] temp_value,
  input wire [31:0] timestamp,
  input wire [15:0] step_count,
  input wire [15:0] rot_x,
  input wire [15:0] rot_y,
  input wire [15:0] rot_z,
  input wire [15:0] grav_x,
  input wire [15:0] grav_y,
  input wire [15:0] grav_z,
  input wire [15:0] bias_x,
  input wire [15:0] bias_y,
  input wire [15:0] bias_z,
  // State seen by the sensor path
  output reg [1:0] time_slot_counter,
  output reg ch2_batch_state,
  output reg gyro_startup_busy
);

  // Source indices, lowest wins a push slot
  localparam S_GYRO = 4'd0;
  localparam S_ACCEL = 4'd1;
  localparam S_CH2 = 4'd2;
  localparam S_FE = 4'd3;
  localparam S_CFG = 4'd4;
  localparam S_TS = 4'd5;
  localparam S_TEMP = 4'd6;
  localparam S_STEP = 4'd7;
  localparam S_ROT = 4'd8;
  localparam S_GRAV = 4'd9;
  localparam S_BIAS = 4'd10;
  localparam S_NONE = 4'd15;

  // Configuration registers
  reg [7:0] brate_r;
  reg [7:0] orate_r;
  reg [7:0] mode_r;
  reg [7:0] gycfg_r;
  reg [7:0] xlcfg_r;
  reg [7:0] batch_r;
  reg [7:0] auxv_r;

  wire [3:0] accel_batch_rate = brate_r[3:0];
  wire [3:0] gyro_batch_rate = brate_r[7:4];
  wire [3:0] accel_output_rate = orate_r[3:0];
  wire [3:0] gyro_output_rate = orate_r[7:4];
  wire [2:0] accel_op_mode = mode_r[2:0];
  wire [2:0] gyro_op_mode = mode_r[6:4];
  wire gyro_filter_enable = mode_r[7];
  wire [2:0] gyro_filter_bandwidth = gycfg_r[2:0];
  wire [2:0] gyro_full_scale = gycfg_r[7:5];
  wire accel_filter_enable = xlcfg_r[0];
  wire [2:0] accel_filter_bandwidth = xlcfg_r[3:1];
  wire frontend_batch_enable = xlcfg_r[4];
  wire [1:0] accel_full_scale = xlcfg_r[7:6];
  wire ch2_batch_host_enable = batch_r[`SFWF_B_CH2_HOST];
  wire ch2_batch_fsm_enable = batch_r[`SFWF_B_CH2_FSM];
  wire frontend_notch_select = batch_r[`SFWF_B_NOTCH];
  wire cfg_change_batch_enable = batch_r[`SFWF_B_CFGCHG];
  wire runtime_compression_enable = batch_r[`SFWF_B_COMPR];
  wire timestamp_enable = batch_r[`SFWF_B_TS_EN];
  wire pedometer_enable = batch_r[`SFWF_B_PEDO];
  wire step_batch_enable = batch_r[`SFWF_B_STEP];
  wire [1:0] temp_batch_rate = auxv_r[1:0];
  wire [1:0] timestamp_decimation = auxv_r[3:2];
  wire rotation_batch_enable = auxv_r[`SFWF_B_ROT];
  wire gravity_batch_enable = auxv_r[`SFWF_B_GRAV];
  wire bias_batch_enable = auxv_r[`SFWF_B_BIAS];

  // Word store and pointers
  reg [55:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;

  reg [10:0] pend_r;
  reg aux_arm_r;
  reg cfg_req_r;
  reg fe_phase_r;
  reg [5:0] ts_dec_cnt_r;
  reg [31:0] start_cnt_r;

  // Picks the lowest set index of the eligible mask
  function [3:0] sfwf_first;
    input [10:0] m;
    integer i;
    begin
      sfwf_first = S_NONE;
      for (i = 10; i >= 0; i = i - 1) begin
        if (m[i]) begin
          sfwf_first = i[3:0];
        end
      end
    end
  endfunction

  // Decimation period for the timestamp field
  function [5:0] sfwf_dec;
    input [1:0] f;
    begin
      case (f)
        2'd1: sfwf_dec = `SFWF_DEC1;
        2'd2: sfwf_dec = `SFWF_DEC2;
        default: sfwf_dec = `SFWF_DEC3;
      endcase
    end
  endfunction

  // Batch events of each source
  wire ch2_state_nxt = ch2_batch_host_enable |
    (ch2_batch_fsm_enable & ch2_fsm_request);
  wire g_evt = gyro_bdr_tick & (|gyro_batch_rate);
  wire a_evt = accel_bdr_tick & (|accel_batch_rate);
  wire c_evt = accel_odr_tick & ch2_batch_state;
  wire f_evt = fe_tick_240 & frontend_batch_enable &
    (~frontend_notch_select | fe_phase_r);
  wire main_evt = g_evt | a_evt | c_evt | f_evt;
  wire step_ok = step_evt & pedometer_enable & step_batch_enable;
  wire rot_ok = fusion_tick & rotation_batch_enable;
  wire grav_ok = fusion_tick & gravity_batch_enable;
  wire bias_ok = fusion_tick & bias_batch_enable;
  wire virt_evt = step_ok | rot_ok | grav_ok | bias_ok;
  wire temp_ok = temp_tick & (|temp_batch_rate);
  wire ts_run = timestamp_enable & (|timestamp_decimation);
  wire ts_hit = main_evt & ts_run &
    (ts_dec_cnt_r >= sfwf_dec(timestamp_decimation) - 6'd1);
  wire cfg_fire = cfg_req_r & (main_evt | virt_evt);

  // Auxiliary words only drain behind a main event or a config firing, and behind the main words
  wire aux_ok = aux_arm_r & ~(|pend_r[3:0]);
  wire [10:0] elig = pend_r & {4'hF, aux_ok, aux_ok, aux_ok, 4'hF};
  wire full = (count_r == DEPTH[AW:0]);
  wire [3:0] sel = full ? S_NONE : sfwf_first(elig);
  wire push = (sel != S_NONE);
  wire pop = reg_rd & (reg_addr == `SFWF_A_BYTE5) & (count_r != 0);

  wire [10:0] set_vec = {bias_ok, grav_ok, rot_ok, step_ok, temp_ok,
    ts_hit | cfg_fire, cfg_fire, f_evt, c_evt, a_evt, g_evt};
  wire [10:0] clr_vec = push ? (11'h001 << sel) : 11'h000;

  // Word assembly for the selected source
  reg [4:0] code;
  reg [47:0] data;
  always @* begin
    code = `SFWF_T_EMPTY;
    data = 48'h0000_0000_0000;
    case (sel)
      S_GYRO: begin
        code = `SFWF_T_GYRO;
        data = {gyro_z, gyro_y, gyro_x};
      end
      S_ACCEL: begin
        code = `SFWF_T_ACCEL;
        data = {accel_x, accel_y, accel_z};
      end
      S_CH2: begin
        code = `SFWF_T_CH2;
        data = {ch2_x, ch2_y, ch2_z};
      end
      S_FE: begin
        code = `SFWF_T_FE;
        data = {32'h0000_0000, fe_sample};
      end
      S_CFG: begin
        code = `SFWF_T_CFG;
        data = {gyro_batch_rate, accel_batch_rate,
          gyro_output_rate, accel_output_rate,
          runtime_compression_enable, gyro_startup_busy, ch2_batch_state, 5'h00,
          accel_full_scale, 1'b0, frontend_batch_enable,
          accel_filter_bandwidth, accel_filter_enable,
          gyro_full_scale, 2'h0, gyro_filter_bandwidth,
          gyro_filter_enable, gyro_op_mode, 1'b0, accel_op_mode};
      end
      S_TS: begin
        code = `SFWF_T_TS;
        data = {gyro_batch_rate, accel_batch_rate,
          1'b0, frontend_batch_enable, ch2_batch_state, 5'h00,
          timestamp};
      end
      S_TEMP: begin
        code = `SFWF_T_TEMP;
        data = {32'h0000_0000, temp_value};
      end
      S_STEP: begin
        code = `SFWF_T_STEP;
        data = {timestamp, step_count};
      end
      S_ROT: begin
        code = `SFWF_T_ROT;
        data = {rot_z, rot_y, rot_x};
      end
      S_GRAV: begin
        code = `SFWF_T_GRAV;
        data = {grav_x, grav_y, grav_z};
      end
      S_BIAS: begin
        code = `SFWF_T_BIAS;
        data = {bias_z, bias_y, bias_x};
      end
      default: begin
        code = `SFWF_T_EMPTY;
        data = 48'h0000_0000_0000;
      end
    endcase
  end

  // Head word; an empty store reads as the empty code
  wire [55:0] head = (count_r != 0) ? mem[rd_ptr_r] : 56'h0000_0000_0000_00;

  // A write to a supported setting register, or a channel 2 flip, asks for a config word
  wire cfg_addr = (reg_addr == `SFWF_A_BRATE) | (reg_addr == `SFWF_A_ORATE) |
    (reg_addr == `SFWF_A_MODE) | (reg_addr == `SFWF_A_GYCFG) |
    (reg_addr == `SFWF_A_XLCFG) | (reg_addr == `SFWF_A_BATCH);
  wire ch2_flip = ch2_state_nxt != ch2_batch_state;
  wire cfg_set = cfg_change_batch_enable & ((reg_wr & cfg_addr) | ch2_flip);
  wire gyro_wake = reg_wr & (reg_addr == `SFWF_A_MODE) &
    (gyro_op_mode == 3'h0) & (reg_wdata[6:4] != 3'h0);

  // Configuration register writes
  always @(posedge clock) begin
    if (sys_rst) begin
      brate_r <= `SFWF_CFG_RST;
      orate_r <= `SFWF_CFG_RST;
      mode_r <= `SFWF_CFG_RST;
      gycfg_r <= `SFWF_CFG_RST;
      xlcfg_r <= `SFWF_CFG_RST;
      batch_r <= `SFWF_CFG_RST;
      auxv_r <= `SFWF_CFG_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `SFWF_A_BRATE: brate_r <= reg_wdata;
        `SFWF_A_ORATE: orate_r <= reg_wdata;
        `SFWF_A_MODE: mode_r <= reg_wdata;
        `SFWF_A_GYCFG: gycfg_r <= reg_wdata;
        `SFWF_A_XLCFG: xlcfg_r <= reg_wdata;
        `SFWF_A_BATCH: batch_r <= reg_wdata;
        `SFWF_A_AUXV: auxv_r <= reg_wdata;
        default: brate_r <= brate_r;
      endcase
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SFWF_A_TAG: reg_rdata <= head[7:0];
        `SFWF_A_BYTE0: reg_rdata <= head[15:8];
        `SFWF_A_BYTE1: reg_rdata <= head[23:16];
        `SFWF_A_BYTE2: reg_rdata <= head[31:24];
        `SFWF_A_BYTE3: reg_rdata <= head[39:32];
        `SFWF_A_BYTE4: reg_rdata <= head[47:40];
        `SFWF_A_BYTE5: reg_rdata <= head[55:48];
        `SFWF_A_BRATE: reg_rdata <= brate_r;
        `SFWF_A_ORATE: reg_rdata <= orate_r;
        `SFWF_A_MODE: reg_rdata <= mode_r;
        `SFWF_A_GYCFG: reg_rdata <= gycfg_r;
        `SFWF_A_XLCFG: reg_rdata <= xlcfg_r;
        `SFWF_A_BATCH: reg_rdata <= batch_r;
        `SFWF_A_AUXV: reg_rdata <= auxv_r;
        `SFWF_A_LEVEL: reg_rdata <= {{(7 - AW){1'b0}}, count_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Word store; tag carries code and slot, bit 0 reads zero
  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r] <= {data, code, time_slot_counter, 1'b0};
    end
  end

  // Pointers and fill level; a full store stalls the pending sources
  always @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW + 1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // Pending flags; a new event wins over the clear of its own push
  always @(posedge clock) begin
    if (sys_rst) begin
      pend_r <= 11'h000;
      aux_arm_r <= 1'b0;
    end else begin
      pend_r <= (pend_r & ~clr_vec) | set_vec;
      if (main_evt | cfg_fire) begin
        aux_arm_r <= 1'b1;
      end else if (aux_ok & ~(|pend_r[6:4])) begin
        aux_arm_r <= 1'b0;
      end
    end
  end

  // Slot counter advances once per cycle that holds a main event;
  // aligned ticks of slower sources fold into the fastest one
  always @(posedge clock) begin
    if (sys_rst) begin
      time_slot_counter <= 2'b00;
    end else if (main_evt) begin
      time_slot_counter <= time_slot_counter + 2'b01;
    end
  end

  // Timestamp decimation counts slots
  always @(posedge clock) begin
    if (sys_rst) begin
      ts_dec_cnt_r <= 6'h00;
    end else if (~ts_run) begin
      ts_dec_cnt_r <= 6'h00;
    end else if (main_evt) begin
      ts_dec_cnt_r <= ts_hit ? 6'h00 : ts_dec_cnt_r + 6'h01;
    end
  end

  // Front-end phase halves the 240 Hz tick when the notch is on
  always @(posedge clock) begin
    if (sys_rst) begin
      fe_phase_r <= 1'b0;
    end else if (fe_tick_240) begin
      fe_phase_r <= ~fe_phase_r;
    end
  end

  // Channel 2 state; the change is seen with a cycle of lag, so one
  // sample may land on the wrong side of the config word
  always @(posedge clock) begin
    if (sys_rst) begin
      ch2_batch_state <= 1'b0;
    end else begin
      ch2_batch_state <= ch2_state_nxt;
    end
  end

  // Config request; a new change wins over the firing clear
  always @(posedge clock) begin
    if (sys_rst) begin
      cfg_req_r <= 1'b0;
    end else if (cfg_set) begin
      cfg_req_r <= 1'b1;
    end else if (cfg_fire) begin
      cfg_req_r <= 1'b0;
    end
  end

  // Gyro startup window after leaving power-down
  always @(posedge clock) begin
    if (sys_rst) begin
      start_cnt_r <= 32'h0000_0000;
      gyro_startup_busy <= 1'b0;
    end else if (gyro_wake) begin
      start_cnt_r <= GYRO_START_CYCLES[31:0];
      gyro_startup_busy <= 1'b1;
    end else if (start_cnt_r > 32'h0000_0001) begin
      start_cnt_r <= start_cnt_r - 32'h0000_0001;
    end else begin
      start_cnt_r <= 32'h0000_0000;
      gyro_startup_busy <= 1'b0;
    end
  end

endmodule

// ---- testbench/sfwf_formatter_chk.sv ----
`timescale 1ns/1ps
`include "sfwf_map.vh"
// Port-level checks of the word formatter; only design-driven signals are judged
module sfwf_formatter_chk #(
  parameter GYRO_START_CYCLES = 20
) (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Rate ticks
  input wire accel_bdr_tick,
  input wire gyro_bdr_tick,
  input wire accel_odr_tick,
  input wire fe_tick_240,
  input wire ch2_fsm_request,
  // State toward the sensor path
  input wire [1:0] time_slot_counter,
  input wire ch2_batch_state,
  input wire gyro_startup_busy
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // Any tick that could open a new time slot
  wire main_tick = accel_bdr_tick | gyro_bdr_tick | accel_odr_tick | fe_tick_240;
  int busy_cnt_r;
  // Length of the current busy stretch; a stuck flag runs it past the limit
  always @(posedge clock) begin
    if (sys_rst || !gyro_startup_busy) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= busy_cnt_r + 1;
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data seen outside its cycle");
  a_rd_unmapped: assert property (
    reg_rd && (reg_addr < 8'h10 || reg_addr > 8'h7E) |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_slot_hold: assert property ((!main_tick) [*2] |=> $stable(time_slot_counter))
    else $error("slot counter moved without a main event");
  a_slot_step: assert property (
    !$past(sys_rst) && $changed(time_slot_counter) |->
    time_slot_counter == $past(time_slot_counter) + 2'd1)
    else $error("slot counter did not step by one");
  a_busy_bound: assert property (busy_cnt_r <= GYRO_START_CYCLES)
    else $error("gyro startup flag held too long");
  a_busy_start: assert property (
    $rose(gyro_startup_busy) |-> $past(reg_wr) && $past(reg_addr) == `SFWF_A_MODE)
    else $error("gyro startup flag rose without a mode write");
  a_ch2_host: assert property (
    reg_wr && reg_addr == `SFWF_A_BATCH && reg_wdata[0] |-> ##2 ch2_batch_state)
    else $error("host enable did not start channel 2 batching");
  a_ch2_cause: assert property (
    !$past(sys_rst) && $changed(ch2_batch_state) |->
    $past(reg_wr && reg_addr == `SFWF_A_BATCH, 2) ||
    $past(ch2_fsm_request) != $past(ch2_fsm_request, 2))
    else $error("channel 2 state changed without cause");
endmodule

bind sfwf_formatter sfwf_formatter_chk #(.GYRO_START_CYCLES(GYRO_START_CYCLES)) u_chk (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .accel_bdr_tick(accel_bdr_tick), .gyro_bdr_tick(gyro_bdr_tick),
  .accel_odr_tick(accel_odr_tick), .fe_tick_240(fe_tick_240),
  .ch2_fsm_request(ch2_fsm_request), .time_slot_counter(time_slot_counter),
  .ch2_batch_state(ch2_batch_state), .gyro_startup_busy(gyro_startup_busy)
);

// ---- testbench/sfwf_host.sv ----
`timescale 1ns/1ps
`include "sfwf_map.vh"
// Host on the register port; one access at a time, no wait states
module sfwf_host (
  // Clock
  input wire logic clock,
  // Register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // Quiet bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released lines are scrambled so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
  // Whole word, tag first; the last byte pops it
  task automatic rdw(output logic [55:0] w);
    logic [7:0] b;
    w = 56'h0;
    for (int i = 0; i < 7; i++) begin
      rd(`SFWF_A_TAG + i[7:0], b);
      w = {w[47:0], b};
    end
  endtask
endmodule

// ---- testbench/sfwf_formatter_tb_top.sv ----
`timescale 1ns/1ps
`include "sfwf_map.vh"
module sfwf_formatter_tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
  logic reg_wr, reg_rd, ch2_batch_state, gyro_startup_busy;
  logic req = 1'b0;
  logic [6:0] tk = 7'h00;
  logic [15:0] d [21];
  logic [31:0] ts = 32'h0;
  logic [1:0] time_slot_counter;
  logic [7:0] rg [8];
  logic [55:0] w;
  int fails = 0;
  int checked = 0;

  sfwf_formatter #(.GYRO_START_CYCLES(20)) u_sfwf_formatter (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .accel_bdr_tick(tk[0]), .gyro_bdr_tick(tk[1]), .accel_odr_tick(tk[2]),
    .fe_tick_240(tk[3]), .temp_tick(tk[4]), .fusion_tick(tk[5]), .step_evt(tk[6]),
    .ch2_fsm_request(req), .accel_x(d[0]), .accel_y(d[1]), .accel_z(d[2]),
    .gyro_x(d[3]), .gyro_y(d[4]), .gyro_z(d[5]), .ch2_x(d[6]), .ch2_y(d[7]),
    .ch2_z(d[8]), .fe_sample(d[9]), .temp_value(d[10]), .timestamp(ts),
    .step_count(d[11]), .rot_x(d[12]), .rot_y(d[13]), .rot_z(d[14]),
    .grav_x(d[15]), .grav_y(d[16]), .grav_z(d[17]), .bias_x(d[18]), .bias_y(d[19]),
    .bias_z(d[20]), .time_slot_counter(time_slot_counter),
    .ch2_batch_state(ch2_batch_state), .gyro_startup_busy(gyro_startup_busy)
  );
  sfwf_host u_sfwf_host (
    .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  // Free-running 25 MHz clock
  initial begin
    forever #20 clock = ~clock;
  end
  // Word from three 16-bit fields, each low byte first; slot bits left out
  function automatic logic [55:0] f3(input logic [4:0] c, input logic [15:0] x, y, z);
    f3 = {c, 3'b000, x[7:0], x[15:8], y[7:0], y[15:8], z[7:0], z[15:8]};
  endfunction
  // Timestamp word with its batch metainformation
  function automatic logic [55:0] tw();
    tw = f3(`SFWF_T_TS, ts[15:0], ts[31:16], {rg[0], 1'b0, rg[4][4], 6'h00});
  endfunction
  task automatic ck(input string n, input logic [55:0] e, input logic [55:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Register writes are mirrored so expectations follow the programmed state
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_sfwf_host.wr(a, v);
    if (a >= `SFWF_A_BRATE && a < `SFWF_A_LEVEL) rg[a[2:0]] = v;
  endtask
  task automatic cw(input string n, input logic [55:0] e);
    u_sfwf_host.rdw(w);
    ck(n, e, w & 56'hF9FF_FFFF_FFFF_FF);
  endtask
  task automatic lv(input logic [7:0] e);
    u_sfwf_host.rd(`SFWF_A_LEVEL, b);
    ck("level", e, b);
  endtask
  // One-cycle ticks, then room for every pending word to land
  task automatic pulse(input logic [6:0] m);
    @(posedge clock);
    tk <= m;
    @(posedge clock);
    tk <= 7'h00;
    repeat (12) @(posedge clock);
  endtask
  task automatic rnd();
    @(posedge clock);
    foreach (d[i]) d[i] <= 16'($urandom);
    ts <= $urandom;
  endtask
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    results();
  end

  initial begin
    foreach (d[i]) d[i] = 16'h0000;
    foreach (rg[i]) rg[i] = 8'h00;
    void'($urandom(32'h1f1f));
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    cw("empty", 56'h0);
    u_sfwf_host.rd(8'h05, b);
    ck("unmapped", 8'h00, b);
    // Batch rates kept at or below the output rates
    wr(`SFWF_A_BRATE, 8'h11);
    wr(`SFWF_A_ORATE, 8'h22);
    // Five gyro events walk the slot counter through its wrap
    for (int i = 1; i < 6; i++) begin
      rnd();
      pulse(7'h02);
      ck("slot", i[1:0], time_slot_counter);
      cw("gyro", f3(`SFWF_T_GYRO, d[3], d[4], d[5]));
    end
    // Temperature alone never writes; it rides on the next main event
    wr(`SFWF_A_AUXV, 8'h01);
    pulse(7'h10);
    lv(8'h00);
    pulse(7'h03);
    ck("slot", 2'd2, time_slot_counter);
    cw("gyro", f3(`SFWF_T_GYRO, d[3], d[4], d[5]));
    cw("accel", f3(`SFWF_T_ACCEL, d[2], d[1], d[0]));
    cw("temp", f3(`SFWF_T_TEMP, d[10], 16'h0, 16'h0));
    wr(`SFWF_A_AUXV, 8'h00);
    // Front-end at full rate, then halved with the notch selected
    wr(`SFWF_A_XLCFG, 8'h10);
    pulse(7'h08);
    cw("fe", f3(`SFWF_T_FE, d[9], 16'h0, 16'h0));
    wr(`SFWF_A_BATCH, 8'h04);
    pulse(7'h08);
    pulse(7'h08);
    lv(8'h01);
    cw("fe", f3(`SFWF_T_FE, d[9], 16'h0, 16'h0));
    // Channel 2 by host enable, then by state-machine request
    wr(`SFWF_A_BATCH, 8'h01);
    rnd();
    pulse(7'h04);
    ck("ch2 state", 1'b1, ch2_batch_state);
    cw("ch2", f3(`SFWF_T_CH2, d[8], d[7], d[6]));
    wr(`SFWF_A_BATCH, 8'h02);
    req <= 1'b1;
    pulse(7'h04);
    ck("ch2 state", 1'b1, ch2_batch_state);
    cw("ch2", f3(`SFWF_T_CH2, d[8], d[7], d[6]));
    req <= 1'b0;
    wr(`SFWF_A_BATCH, 8'h00);
    pulse(7'h04);
    lv(8'h00);
    // Virtual sources, each gated by its own enable
    wr(`SFWF_A_BATCH, 8'h80);
    pulse(7'h40);
    lv(8'h00);
    wr(`SFWF_A_BATCH, 8'hC0);
    wr(`SFWF_A_AUXV, 8'h70);
    rnd();
    pulse(7'h60);
    cw("step", f3(`SFWF_T_STEP, d[11], ts[15:0], ts[31:16]));
    cw("rot", f3(`SFWF_T_ROT, d[12], d[13], d[14]));
    cw("grav", f3(`SFWF_T_GRAV, d[17], d[16], d[15]));
    cw("bias", f3(`SFWF_T_BIAS, d[18], d[19], d[20]));
    wr(`SFWF_A_AUXV, 8'h00);
    pulse(7'h20);
    lv(8'h00);
    // Timestamp needs both its enable and a decimation setting
    wr(`SFWF_A_BATCH, 8'h20);
    wr(`SFWF_A_AUXV, 8'h04);
    rnd();
    pulse(7'h02);
    cw("gyro", f3(`SFWF_T_GYRO, d[3], d[4], d[5]));
    cw("ts", tw());
    wr(`SFWF_A_AUXV, 8'h00);
    pulse(7'h02);
    lv(8'h01);
    cw("gyro", f3(`SFWF_T_GYRO, d[3], d[4], d[5]));
    // Second decimation setting: one timestamp every eighth slot
    wr(`SFWF_A_AUXV, 8'h08);
    for (int i = 0; i < 8; i++) begin
      pulse(7'h02);
      cw("gyro", f3(`SFWF_T_GYRO, d[3], d[4], d[5]));
    end
    cw("ts", tw());
    wr(`SFWF_A_AUXV, 8'h00);
    // Config change during gyro startup, timestamp forced though disabled
    wr(`SFWF_A_BATCH, 8'h08);
    wr(`SFWF_A_MODE, 8'h11);
    rnd();
    pulse(7'h02);
    cw("gyro", f3(`SFWF_T_GYRO, d[3], d[4], d[5]));
    cw("cfg", f3(`SFWF_T_CFG, {rg[3], rg[2]}, {8'h40, rg[4]}, {rg[0], rg[1]}));
    cw("ts", tw());
    repeat (30) @(posedge clock);
    #1;
    ck("busy", 1'b0, gyro_startup_busy);
    results();
  end
endmodule
